//--- channel_readback_word.sv
// Channel readback word register bank with temperature alarm and interrupt
//
// Chosen here: the placing of the registers and strobed register access.
`default_nettype none

// Summary of operation
// RULE_01: Readback is one 24-bit word holding type bits and channel status bits.
// RULE_02: Each readback reports exactly one channel, the one currently selected.
// RULE_03: Word-type bits 23 and 22 read as zero in the channel word.
// RULE_04: Bit 21 is one when the selected channel is enabled.
// RULE_05: Bits 20:19 give the force mode of the selected channel.
// RULE_06: Bits 17:15 give the three-bit current range code.
// RULE_07: Bits 14:13 give the measure-output selection.
// RULE_08: Bit 12 shows the force amplifier input switch.
// RULE_09: Bits 11 and 10 show system force and sense line connection.
// RULE_10: Bit 9 shows the current clamp enable of the selected channel.
// RULE_11: Clamp enable reflects the last write, system or channel register.
// RULE_12: Bit 8 shows the comparator output enable of the channel.
// RULE_13: Comparator enable reflects the last write, system or channel register.
// RULE_14: Bit 7 is one for voltage compare, zero for current compare.
// RULE_15: Live alarm bit mirrors the open-drain temperature alarm output.
// RULE_16: Bit 6 latched alarm, bit 5 live alarm, same for every channel.
// RULE_17: Writing one to bit 6 of a channel write clears the latched alarm.
// RULE_18: Bit 18 and bits 4 to 0 read as zero.
module channel_readback_word
    import chan_rb_pkg::*;
(
    input wire logic clk, // 200 MHz clock
    input wire logic rst_b, // Async reset, low
    input wire regbus_req_s bus_req, // Register strobes, address, data
    output logic [DATA_W-1:0] rd_data, // Read data, cycle after strobe
    input wire logic heat_over, // Junction over temperature, async pin
    output logic heat_alarm_o, // Open-drain alarm level, always low
    output logic heat_alarm_oe, // Alarm pin pulled low while high
    output logic irq // Level interrupt
);

    chan_cfg_s cfg_r [NUM_CH];
    logic [NUM_CH-1:0] limiter_on_r;
    logic [NUM_CH-1:0] comparator_out_on_r;
    logic [SEL_W-1:0] sel_r;
    logic [SYNC_LEN-1:0] heat_sync_r;
    logic heat_live_r;
    logic held_heat_alarm_r;
    logic heat_alarm_oe_r;
    logic heat_alarm_o_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_stat_nxt;
    logic [IRQ_W-1:0] irq_en_r;
    logic irq_r;
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;
    logic [NUM_CH-1:0] chan_hit;
    logic chan_wr;
    logic clear_wr;
    logic sys_wr;
    logic [WORD_W-1:0] word_sel;

    assign rd_data = rd_data_r;
    assign heat_alarm_o = heat_alarm_o_r;
    assign heat_alarm_oe = heat_alarm_oe_r;
    assign irq = irq_r;

    // Channel fields at readback positions; alarm and type bits left zero
    function automatic logic [WORD_W-1:0] pack_cfg(
        input chan_cfg_s c,
        input logic lim,
        input logic cmp
    );
        logic [WORD_W-1:0] w;
        w = '0; // [RULE_18]
        w[POS_CHAN_ON] = c.channel_on; // [RULE_04]
        w[POS_FORCE_HI:POS_FORCE_LO] = c.force_kind; // [RULE_05]
        w[POS_RANGE_HI:POS_RANGE_LO] = c.range_code; // [RULE_06]
        w[POS_MEAS_HI:POS_MEAS_LO] = c.measure_select; // [RULE_07]
        w[POS_FORCE_IN] = c.force_input_link; // [RULE_08]
        w[POS_SF] = c.sys_force_link; // [RULE_09]
        w[POS_SS] = c.sys_sense_link; // [RULE_09]
        w[POS_LIM] = lim; // [RULE_10]
        w[POS_CMP] = cmp; // [RULE_12]
        w[POS_CVI] = c.compare_voltage; // [RULE_14]
        return w;
    endfunction : pack_cfg

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            chan_hit[i] = bus_req.addr == ADDR_W'(OFS_CHAN0 + i * CHAN_STRIDE);
        end
    end

    assign chan_wr = bus_req.wr && (|chan_hit);
    assign clear_wr = chan_wr && bus_req.wdata[POS_CLEAR]; // [RULE_17]
    assign sys_wr = bus_req.wr && bus_req.addr == OFS_SYS;

    // Only the selected channel enters the word; device alarms are shared
    always_comb begin
        word_sel = pack_cfg(cfg_r[sel_r], limiter_on_r[sel_r],
            comparator_out_on_r[sel_r]); // [RULE_02]
        word_sel[POS_TYPE_HI] = 1'b0; // [RULE_03]
        word_sel[POS_TYPE_LO] = 1'b0; // [RULE_03]
        word_sel[POS_HELD] = held_heat_alarm_r; // [RULE_16]
        word_sel[POS_LIVE] = heat_alarm_oe_r; // [RULE_15]
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_CH; i++) begin
                cfg_r[i] <= RST_CFG;
            end
        end else if (bus_req.wr) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (chan_hit[i]) begin
                    cfg_r[i].channel_on <= bus_req.wdata[POS_CHAN_ON];
                    cfg_r[i].force_kind <=
                        force_kind_e'(bus_req.wdata[POS_FORCE_HI:POS_FORCE_LO]);
                    cfg_r[i].range_code <= bus_req.wdata[POS_RANGE_HI:POS_RANGE_LO];
                    cfg_r[i].measure_select <=
                        measure_e'(bus_req.wdata[POS_MEAS_HI:POS_MEAS_LO]);
                    cfg_r[i].force_input_link <= bus_req.wdata[POS_FORCE_IN];
                    cfg_r[i].sys_force_link <= bus_req.wdata[POS_SF];
                    cfg_r[i].sys_sense_link <= bus_req.wdata[POS_SS];
                    cfg_r[i].compare_voltage <= bus_req.wdata[POS_CVI];
                end
            end
        end
    end

    // Both paths write the same flop, so the later write is what reads back
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            limiter_on_r <= RST_CH_BITS;
            comparator_out_on_r <= RST_CH_BITS;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (bus_req.wr && chan_hit[i]) begin
                    limiter_on_r[i] <= bus_req.wdata[POS_LIM]; // [RULE_11]
                    comparator_out_on_r[i] <= bus_req.wdata[POS_CMP]; // [RULE_13]
                end else if (sys_wr) begin
                    limiter_on_r[i] <= bus_req.wdata[POS_SYS_LIM + i]; // [RULE_11]
                    comparator_out_on_r[i] <= bus_req.wdata[POS_SYS_CMP + i]; // [RULE_13]
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_r <= RST_SEL;
        end else if (bus_req.wr && bus_req.addr == OFS_SEL) begin
            sel_r <= bus_req.wdata[SEL_W-1:0]; // [RULE_02]
        end
    end

    // Three-stage synchroniser; a level is accepted once stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            heat_sync_r <= RST_SYNC;
        end else begin
            heat_sync_r <= {heat_sync_r[1:0], heat_over};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            heat_live_r <= 1'b0;
        end else if (heat_sync_r[1] == heat_sync_r[2]) begin
            heat_live_r <= heat_sync_r[2];
        end
    end

    // Pin driver and live bit share one flop so they never disagree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            heat_alarm_oe_r <= 1'b0;
            heat_alarm_o_r <= 1'b0;
        end else begin
            heat_alarm_oe_r <= heat_live_r; // [RULE_15]
            heat_alarm_o_r <= 1'b0;
        end
    end

    // A clear while the condition persists has no effect: set wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            held_heat_alarm_r <= 1'b0;
        end else if (heat_live_r) begin
            held_heat_alarm_r <= 1'b1; // [RULE_16]
        end else if (clear_wr) begin
            held_heat_alarm_r <= 1'b0; // [RULE_17]
        end
    end

    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (bus_req.wr && bus_req.addr == OFS_IRQ_CLR) begin
            irq_stat_nxt = irq_stat_r & ~bus_req.wdata[IRQ_W-1:0];
        end
        if (heat_live_r && !heat_alarm_oe_r) begin
            irq_stat_nxt[IRQ_HEAT_RISE] = 1'b1;
        end
        if (!heat_live_r && heat_alarm_oe_r) begin
            irq_stat_nxt[IRQ_HEAT_FALL] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_r <= RST_IRQ;
            irq_en_r <= RST_IRQ;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (bus_req.wr && bus_req.addr == OFS_IRQ_EN) begin
                irq_en_r <= bus_req.wdata[IRQ_W-1:0];
            end
            irq_r <= |(irq_stat_r & irq_en_r);
        end
    end

    always_comb begin
        rd_data_nxt = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (chan_hit[i]) begin
                rd_data_nxt[WORD_W-1:0] = pack_cfg(cfg_r[i], limiter_on_r[i],
                    comparator_out_on_r[i]);
            end
        end
        unique case (bus_req.addr)
            OFS_SYS: begin
                rd_data_nxt[POS_SYS_LIM +: NUM_CH] = limiter_on_r;
                rd_data_nxt[POS_SYS_CMP +: NUM_CH] = comparator_out_on_r;
            end
            OFS_SEL: rd_data_nxt[SEL_W-1:0] = sel_r;
            OFS_READBACK: rd_data_nxt[WORD_W-1:0] = word_sel; // [RULE_01]
            OFS_IRQ_STAT: rd_data_nxt[IRQ_W-1:0] = irq_stat_r;
            OFS_IRQ_EN: rd_data_nxt[IRQ_W-1:0] = irq_en_r;
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_r <= '0;
        end else if (bus_req.rd) begin
            rd_data_r <= rd_data_nxt;
        end else begin
            rd_data_r <= '0;
        end
    end

    // Helper terms for the checks below
    logic rd_rb;
    logic wr_sel_chan;
    logic sys_lim_pick;
    logic sys_cmp_pick;
    logic [1:0] sel_force;
    logic [2:0] sel_range;
    logic [1:0] sel_meas;
    logic wr_sel;
    logic new_sel_on;
    logic [2:0] new_sel_range;

    assign rd_rb = bus_req.rd && bus_req.addr == OFS_READBACK;
    assign wr_sel_chan = bus_req.wr
        && bus_req.addr == ADDR_W'(OFS_CHAN0 + sel_r * CHAN_STRIDE);
    assign sys_lim_pick = bus_req.wdata[POS_SYS_LIM + sel_r];
    assign sys_cmp_pick = bus_req.wdata[POS_SYS_CMP + sel_r];
    assign sel_force = cfg_r[sel_r].force_kind;
    assign sel_range = cfg_r[sel_r].range_code;
    assign sel_meas = cfg_r[sel_r].measure_select;
    // Fields of the channel that a select write is about to pick
    assign wr_sel = bus_req.wr && bus_req.addr == OFS_SEL;
    assign new_sel_on = cfg_r[bus_req.wdata[SEL_W-1:0]].channel_on;
    assign new_sel_range = cfg_r[bus_req.wdata[SEL_W-1:0]].range_code;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_rd_rb;
        rd_rb;
    endsequence

    sequence s_sys_then_read;
        sys_wr ##1 rd_rb;
    endsequence

    sequence s_chan_then_read;
        wr_sel_chan ##1 rd_rb;
    endsequence

    sequence s_sel_then_read;
        wr_sel ##1 rd_rb;
    endsequence

    a_type_bits_zero: assert property ( // [RULE_03]
        s_rd_rb |=> rd_data[POS_TYPE_HI:POS_TYPE_LO] == 2'h0
            && rd_data[DATA_W-1:WORD_W] == '0)
        else $error("word type or upper bits not zero");

    a_chan_fields: assert property ( // [RULE_05]
        s_rd_rb |=> rd_data[POS_FORCE_HI:POS_FORCE_LO] == $past(sel_force)
            && rd_data[POS_RANGE_HI:POS_RANGE_LO] == $past(sel_range)
            && rd_data[POS_MEAS_HI:POS_MEAS_LO] == $past(sel_meas))
        else $error("force, range or measure field wrong");

    a_chan_on_write: assert property ( // [RULE_04]
        s_chan_then_read |=> rd_data[POS_CHAN_ON] == $past(bus_req.wdata[POS_CHAN_ON], 2)
            && rd_data[POS_CVI] == $past(bus_req.wdata[POS_CVI], 2)
            && rd_data[POS_FORCE_IN] == $past(bus_req.wdata[POS_FORCE_IN], 2))
        else $error("channel write not seen in readback");

    a_lim_sys_last: assert property ( // [RULE_11]
        s_sys_then_read |=> rd_data[POS_LIM] == $past(sys_lim_pick, 2))
        else $error("clamp enable ignores system write");

    a_cmp_sys_last: assert property ( // [RULE_13]
        s_sys_then_read |=> rd_data[POS_CMP] == $past(sys_cmp_pick, 2))
        else $error("comparator enable ignores system write");

    a_cmp_chan_last: assert property ( // [RULE_12]
        s_chan_then_read |=> rd_data[POS_CMP] == $past(bus_req.wdata[POS_CMP], 2)
            && rd_data[POS_LIM] == $past(bus_req.wdata[POS_LIM], 2))
        else $error("channel enable write not seen");

    a_reserved_zero: assert property ( // [RULE_18]
        s_rd_rb |=> rd_data[POS_RSVD] == 1'b0
            && rd_data[POS_UNUSED_HI:0] == '0)
        else $error("reserved readback bits not zero");

    a_live_mirror: assert property ( // [RULE_15]
        s_rd_rb |=> rd_data[POS_LIVE] == $past(heat_alarm_oe))
        else $error("live alarm bit differs from pin");

    a_pin_follow: assert property ( // [RULE_15]
        heat_over [*6] |=> heat_alarm_oe)
        else $error("alarm pin not driven after over temperature");

    // A short alarm pulse may be cleared soon after, so only a clear may drop the latch
    a_held_sticky: assert property ( // [RULE_16]
        (held_heat_alarm_r && !clear_wr) |=> held_heat_alarm_r)
        else $error("latched alarm did not stay set");

    a_held_set: assert property ( // [RULE_16]
        heat_live_r |=> held_heat_alarm_r)
        else $error("latched alarm not set by live alarm");

    a_sel_switch: assert property ( // [RULE_02]
        s_sel_then_read |=> rd_data[POS_CHAN_ON] == $past(new_sel_on, 2)
            && rd_data[POS_RANGE_HI:POS_RANGE_LO] == $past(new_sel_range, 2))
        else $error("readback does not follow new channel select");

    a_held_clear: assert property ( // [RULE_17]
        (clear_wr && !heat_live_r && held_heat_alarm_r) |=> !held_heat_alarm_r)
        else $error("latched alarm not cleared");

    a_irq_level: assert property (
        (|(irq_stat_r & irq_en_r)) |=> irq)
        else $error("interrupt not raised for enabled status");

    a_irq_quiet: assert property (
        !(|(irq_stat_r & irq_en_r)) |=> !irq)
        else $error("interrupt raised with no enabled status");

    // Edge flags are set even in the cycle of a clear write
    a_rise_flag: assert property (
        (heat_live_r && !heat_alarm_oe_r) |=> irq_stat_r[IRQ_HEAT_RISE])
        else $error("alarm rise flag not set");

    a_fall_flag: assert property (
        (!heat_live_r && heat_alarm_oe_r) |=> irq_stat_r[IRQ_HEAT_FALL])
        else $error("alarm fall flag not set");

    // Read data must not linger, a stale word would look like a fresh answer
    a_rd_idle_zero: assert property (
        !bus_req.rd |=> rd_data == '0)
        else $error("read data not zero outside read answer");

endmodule : channel_readback_word
`default_nettype wire

//--- chan_rb_pkg.sv
// Constants, field layouts and carrier types for the channel readback bank
`default_nettype none
package chan_rb_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned WORD_W = 24;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned SEL_W = 2;
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned SYNC_LEN = 3;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CHAN0 = 8'h00;
    localparam int unsigned CHAN_STRIDE = 4;
    localparam logic [ADDR_W-1:0] OFS_SYS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SEL = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_READBACK = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h24;
    // Readback word and channel write word fields
    localparam int unsigned POS_TYPE_HI = 23;
    localparam int unsigned POS_TYPE_LO = 22;
    localparam int unsigned POS_CHAN_ON = 21;
    localparam int unsigned POS_FORCE_HI = 20;
    localparam int unsigned POS_FORCE_LO = 19;
    localparam int unsigned POS_RSVD = 18;
    localparam int unsigned POS_RANGE_HI = 17;
    localparam int unsigned POS_RANGE_LO = 15;
    localparam int unsigned POS_MEAS_HI = 14;
    localparam int unsigned POS_MEAS_LO = 13;
    localparam int unsigned POS_FORCE_IN = 12;
    localparam int unsigned POS_SF = 11;
    localparam int unsigned POS_SS = 10;
    localparam int unsigned POS_LIM = 9;
    localparam int unsigned POS_CMP = 8;
    localparam int unsigned POS_CVI = 7;
    localparam int unsigned POS_HELD = 6;
    localparam int unsigned POS_LIVE = 5;
    localparam int unsigned POS_CLEAR = 6;
    localparam int unsigned POS_UNUSED_HI = 4;
    // System control write word fields
    localparam int unsigned POS_SYS_LIM = 0;
    localparam int unsigned POS_SYS_CMP = 4;
    // Interrupt status bits
    localparam int unsigned IRQ_HEAT_RISE = 0;
    localparam int unsigned IRQ_HEAT_FALL = 1;
    // Values after reset
    localparam logic [SEL_W-1:0] RST_SEL = 2'h0;
    localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
    localparam logic [NUM_CH-1:0] RST_CH_BITS = 4'h0;
    localparam logic [SYNC_LEN-1:0] RST_SYNC = 3'h0;

    typedef enum logic [1:0] {
        voltage_force,
        current_force,
        hiz_voltage,
        hiz_current
    } force_kind_e;

    typedef enum logic [1:0] {
        current_sense_node,
        voltage_sense_node,
        temp_sensor_node,
        output_switch_open
    } measure_e;

    typedef struct packed {
        logic channel_on;
        force_kind_e force_kind;
        logic [2:0] range_code;
        measure_e measure_select;
        logic force_input_link;
        logic sys_force_link;
        logic sys_sense_link;
        logic compare_voltage;
    } chan_cfg_s;

    localparam chan_cfg_s RST_CFG = '0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } regbus_req_s;
endpackage : chan_rb_pkg
`default_nettype wire

//--- alarm_line_model.sv
// Far-side model of the temperature comparator and the pulled-up alarm line
`default_nettype none
module alarm_line_model (
    input wire logic clk, // Bench clock
    input wire logic hot, // Requested over-temperature state
    input wire logic drv_o, // Device pin level
    input wire logic drv_oe, // Device pull-low enable
    output logic heat_over, // Over-temperature level into the device
    output logic alarm_pin // Resolved open-drain line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Comparator output changes off the device clock phase, as a real sensor would
    always @(negedge clk) begin
        heat_over <= hot;
    end
    // Released line floats to the pull-up level
    assign alarm_pin = drv_oe ? drv_o : 1'b1;
endmodule : alarm_line_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the channel readback register bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import chan_rb_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hot = 1'b0;
    regbus_req_s bus_req = '0;
    logic [DATA_W-1:0] rd_data;
    logic heat_over, heat_alarm_o, heat_alarm_oe, irq, alarm_pin;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [DATA_W-1:0] exp_w [NUM_CH];
    logic [DATA_W-1:0] rdv;

    always #2.5 clk = ~clk;

    channel_readback_word channel_readback_word_inst (
        .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .heat_over(heat_over), .heat_alarm_o(heat_alarm_o),
        .heat_alarm_oe(heat_alarm_oe), .irq(irq)
    );
    alarm_line_model alarm_line_model_inst (
        .clk(clk), .hot(hot), .drv_o(heat_alarm_o), .drv_oe(heat_alarm_oe),
        .heat_over(heat_over), .alarm_pin(alarm_pin)
    );

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // Generous ceiling: the whole sequence needs about 115 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] exp);
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        rdv = rd_data;
        check(what, rdv, exp);
    endtask : rdchk

    // Write then read with no idle cycle between the strobes
    task automatic wr_rd(input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] wd,
                         input logic [ADDR_W-1:0] ra, input string what,
                         input logic [DATA_W-1:0] exp);
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: wa, wdata: wd};
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: ra, wdata: '0};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        check(what, rd_data, exp);
    endtask : wr_rd

    task automatic sel_rb(input int ch, input string what, input logic [DATA_W-1:0] exp);
        wr_rd(OFS_SEL, DATA_W'(ch), OFS_READBACK, what, exp);
    endtask : sel_rb

    function automatic logic [ADDR_W-1:0] ch_addr(input int ch);
        return OFS_CHAN0 + ADDR_W'(ch * CHAN_STRIDE);
    endfunction : ch_addr

    // Expected channel word: type bits, reserved bit and low bits all zero
    function automatic logic [DATA_W-1:0] chan_word(input logic on, input logic [1:0] frc,
        input logic [2:0] rng, input logic [1:0] meas, input logic [2:0] links,
        input logic lim, input logic cmp, input logic cvi);
        return {8'h00, 2'b00, on, frc, 1'b0, rng, meas, links, lim, cmp, cvi, 7'h00};
    endfunction : chan_word

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;

        rdchk("readback after reset", OFS_READBACK, 32'h0000_0000);
        rdchk("sys after reset", OFS_SYS, 32'h0000_0000);
        rdchk("irq status after reset", OFS_IRQ_STAT, 32'h0000_0000);
        $display("test reset_values done");

        // Every force and measure code, each on its own channel
        for (int i = 0; i < NUM_CH; i++) begin
            exp_w[i] = chan_word(i[0], 2'(i), 3'(2 * i + 1), 2'(3 - i),
                                 {i[0], i[1], ~i[0]}, i[1], ~i[1], ~i[0]);
            wr(ch_addr(i), exp_w[i]);
        end
        for (int i = 0; i < NUM_CH; i++) begin
            sel_rb(i, "channel readback", exp_w[i]);
            rdchk("channel config", ch_addr(i), exp_w[i]);
        end
        $display("test channel_fields done");

        // System control write then channel write: the later one wins
        for (int i = 0; i < NUM_CH; i++) begin
            exp_w[i][9] = 1'b1;
            exp_w[i][8] = 1'b0;
        end
        wr_rd(OFS_SYS, 32'h0000_000F, OFS_READBACK, "sys then read", exp_w[3]);
        sel_rb(3, "clamp from sys", exp_w[3]);
        sel_rb(0, "clamp from sys ch0", exp_w[0]);
        exp_w[0][9] = 1'b0;
        exp_w[0][8] = 1'b1;
        wr_rd(ch_addr(0), exp_w[0], OFS_READBACK, "clamp from channel", exp_w[0]);
        rdchk("sys after channel write", OFS_SYS, 32'h0000_001E);
        sel_rb(3, "other channel untouched", exp_w[3]);
        $display("test last_write_wins done");

        // Alarm: raise, clear refused while live, drop, clear accepted
        wr(OFS_IRQ_EN, 32'h0000_0003);
        rdchk("irq enable", OFS_IRQ_EN, 32'h0000_0003);
        hot <= 1'b1;
        repeat (8) @(posedge clk);
        check("alarm pin low", DATA_W'(alarm_pin), 32'h0000_0000);
        check("irq on rise", DATA_W'(irq), 32'h0000_0001);
        rdchk("alarm on ch3", OFS_READBACK, exp_w[3] | 32'h0000_0060);
        wr(ch_addr(0), exp_w[0] | 32'h0000_0040);
        sel_rb(2, "clear while live", exp_w[2] | 32'h0000_0060);
        hot <= 1'b0;
        repeat (8) @(posedge clk);
        check("alarm pin released", DATA_W'(alarm_pin), 32'h0000_0001);
        rdchk("latched only", OFS_READBACK, exp_w[2] | 32'h0000_0040);
        rdchk("irq rise and fall", OFS_IRQ_STAT, 32'h0000_0003);
        wr(ch_addr(0), exp_w[0] | 32'h0000_0040);
        rdchk("latch cleared", OFS_READBACK, exp_w[2]);
        sel_rb(0, "clear bit not stored", exp_w[0]);
        $display("test heat_alarm done");

        // Interrupt masking and clearing, refused accesses
        wr(OFS_IRQ_EN, 32'h0000_0000);
        repeat (3) @(posedge clk);
        check("irq masked", DATA_W'(irq), 32'h0000_0000);
        wr(OFS_IRQ_EN, 32'h0000_0002);
        repeat (3) @(posedge clk);
        check("irq fall enabled", DATA_W'(irq), 32'h0000_0001);
        wr(OFS_IRQ_CLR, 32'h0000_0003);
        rdchk("irq status cleared", OFS_IRQ_STAT, 32'h0000_0000);
        check("irq dropped", DATA_W'(irq), 32'h0000_0000);
        rdchk("irq clear reads zero", OFS_IRQ_CLR, 32'h0000_0000);
        wr(8'h30, 32'h0000_FFFF);
        rdchk("unmapped", 8'h30, 32'h0000_0000);
        wr(OFS_READBACK, 32'h00FF_FFFF);
        rdchk("readback is read only", OFS_READBACK, exp_w[0]);
        $display("test irq_and_refusals done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
